// ### shared/iqe_defs.svh
// Constants of the I/Q equalization FIR: widths, limits, reset values, register map.
// Included by the cmac and FIR design files and by the test files; definitions only.
`ifndef IQE_DEFS_SVH
`define IQE_DEFS_SVH
// Data widths and fixed point
`define IQE_DW 16
`define IQE_AW 40
`define IQE_CFRAC 14
`define IQE_UNITY 16'h4000
`define IQE_SMAX 40'sh0000007FFF
`define IQE_SMIN 40'shFFFFFF8000
`define IQE_PMAX 16'sh7FFF
`define IQE_PMIN 16'sh8000
// Limits and reset values
`define IQE_TAP_MIN 9'h002
`define IQE_TAP_MAX 9'h100
`define IQE_OSR_MIN 6'h01
`define IQE_OSR_MAX 6'h20
`define IQE_OSR_RST 6'h04
`define IQE_TBL_MAX 11'h400
`define IQE_SYM_MAX 11'h020
`define IQE_RT_LOG2 3'h4
`define IQE_CH_MAX 7'h40
// Register offsets
`define IQE_A_CTRL 4'h0
`define IQE_A_TAPS 4'h1
`define IQE_A_OSR 4'h2
`define IQE_A_COUNT 4'h3
`define IQE_A_ADDR 4'h4
`define IQE_A_EQDATA 4'h5
`define IQE_A_TBLDATA 4'h6
`define IQE_A_CHDATA 4'h7
`define IQE_A_CHLEN 4'h8
`define IQE_A_STATUS 4'h9
// Control bits
`define IQE_B_EN 0
`define IQE_B_CPLX 1
`define IQE_B_CHOPT 2
`define IQE_B_SKEW 3
`define IQE_B_DELAY 4
`define IQE_B_MOD 5
`define IQE_B_RATE 6
`define IQE_B_BUILD 8
`define IQE_B_MIRROR 9
`endif

// ### shared/iqe_pkg.sv
// Types shared by the I/Q equalization FIR.
// No assumptions beyond a SystemVerilog compiler.
package iqe_pkg;
    typedef enum logic [4:0] {
        IQE_IDLE = 5'h01,
        IQE_BUILD = 5'h02,
        IQE_FILT = 5'h04,
        IQE_EMIT = 5'h08,
        IQE_MIRR = 5'h10
    } iqe_state_e;
endpackage

// ### hw/iqe_cmac.sv
// Complex multiply-accumulate with a real-coefficient mode.
// Assumes the caller clears the sum before each new accumulation.
`timescale 1ns/10ps
`include "iqe_defs.svh"
module iqe_cmac #(
    parameter int DW = `IQE_DW,
    parameter int AW = `IQE_AW
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Control
    input wire logic clr,
    input wire logic en,
    input wire logic realMode,
    // Operands
    input wire logic signed [DW-1:0] aRe,
    input wire logic signed [DW-1:0] aIm,
    input wire logic signed [DW-1:0] bRe,
    input wire logic signed [DW-1:0] bIm,
    // Sums
    output logic signed [AW-1:0] accRe,
    output logic signed [AW-1:0] accIm
);
    logic signed [2*DW-1:0] pRR, pII, pRI, pIR;
    logic signed [AW-1:0] tRe, tIm;
    assign pRR = aRe * bRe;
    assign pII = aIm * bIm;
    assign pRI = aRe * bIm;
    assign pIR = aIm * bRe;
    // Real mode: one real coefficient shared by both rails
    assign tRe = realMode ? AW'(pRR) : AW'(pRR) - AW'(pII);
    assign tIm = realMode ? AW'(pIR) : AW'(pRI) + AW'(pIR);
    always_ff @(posedge clock) begin
        if (!rst_n || clr) begin
            accRe <= '0;
            accIm <= '0;
        end else if (en) begin
            accRe <= accRe + tRe;
            accIm <= accIm + tIm;
        end
    end
    realRail_a: assert property (@(posedge clock) disable iff (!rst_n)
        en && !clr && realMode |=> accIm == $past(accIm) + AW'($past(pIR)))
        else $error("real mode did not filter Q with the shared coefficient");
    crossTerm_a: assert property (@(posedge clock) disable iff (!rst_n)
        en && !clr && !realMode |=> accRe == $past(accRe) + AW'($past(pRR)) - AW'($past(pII)))
        else $error("complex mode lost the I/Q cross term");
endmodule // iqe_cmac

// ### hw/iq_equalization_fir.sv
// I/Q equalization FIR with a real-time modulation filter and coefficient table.
// Assumes one clock, a plain register port, and samples offered with valid/ready.
`timescale 1ns/10ps
`include "iqe_defs.svh"
////////////////////////////////////////////////////////////////////////////////
// What this block does
// - Equalizer accepts 2 to 256 taps; complex taps carry real and imaginary parts.
// - Real mode filters I and Q separately with one shared real coefficient set.
// - Complex mode convolves I+jQ with complex coefficients, coupling the rails.
// - Each sample takes one I and one Q and yields one I and one Q, or optOsr pairs with modulation filtering on.
// - Filter runs at the 200 MHz sample rate; supplier resamples coefficients.
// - With channel optimization, convolve both sets and keep at most the central 248 taps (256 less CHOPT_TAP_CUT).
// - Skew, delay or channel optimization reduce the taps the equalizer may use.
// - An enable control; when cleared no equalization is applied, but modulation filtering still runs.
// - Only internal-source samples are filtered, for RF and external I/Q paths.
// - Table accepts 1 to 32 coefficients per symbol and at most 1024 taps.
// - Modulation filtering takes at most 32 symbols, decimated to 16 or less.
// - A modulation filter is resampled to the internally chosen optimal ratio.
// - With modulation filtering on, each incoming sample is one symbol.
// - Modulation filter builds transitions between symbols; stored data is untouched.
// - Mirror appends coefficients reversed: 16 entries become 32, 16..31 mirror 15..0.
module iq_equalization_fir
    import iqe_pkg::*;
#(
    parameter int SKEW_TAP_CUT = 8,
    parameter int DELAY_TAP_CUT = 8,
    parameter int CHOPT_TAP_CUT = 8
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Register port
    input wire logic [3:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata,
    // Samples from the baseband source
    input wire logic inValid,
    input wire logic srcInternal,
    input wire logic signed [`IQE_DW-1:0] inI,
    input wire logic signed [`IQE_DW-1:0] inQ,
    output logic inReady,
    // Samples towards the RF and external I/Q paths
    output logic outValid,
    output logic signed [`IQE_DW-1:0] outI,
    output logic signed [`IQE_DW-1:0] outQ
);
    localparam int DW = `IQE_DW;
    localparam int AW = `IQE_AW;

    function automatic logic signed [DW-1:0] satq(input logic signed [AW-1:0] a);
        logic signed [AW-1:0] s;
        s = a >>> `IQE_CFRAC;
        if (s > `IQE_SMAX) begin
            satq = `IQE_PMAX;
        end else if (s < `IQE_SMIN) begin
            satq = `IQE_PMIN;
        end else begin
            satq = s[DW-1:0];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // State
    logic [7:0] ctrl_r;
    logic [8:0] taps_r, workLen_r, k_r;
    logic [5:0] osr_r;
    logic [10:0] count_r, j_r, base_r;
    logic [9:0] addr_r;
    logic [6:0] chLen_r;
    logic [7:0] wp_r;
    logic buildReq_r, mirrReq_r, build_r, modeMod_r, bypass_r;
    logic signed [DW-1:0] capI_r, capQ_r, outI_r, outQ_r;
    logic outValid_r;
    logic [31:0] regRdata_r;
    iqe_state_e state_r;
    // Coefficient and history stores
    logic signed [DW-1:0] eqRe [0:`IQE_TAP_MAX-1];
    logic signed [DW-1:0] eqIm [0:`IQE_TAP_MAX-1];
    logic signed [DW-1:0] workRe [0:`IQE_TAP_MAX-1];
    logic signed [DW-1:0] workIm [0:`IQE_TAP_MAX-1];
    logic signed [DW-1:0] histI [0:`IQE_TAP_MAX-1];
    logic signed [DW-1:0] histQ [0:`IQE_TAP_MAX-1];
    logic signed [DW-1:0] tbl [0:`IQE_TBL_MAX-1];
    logic signed [DW-1:0] chCoefMem [0:`IQE_CH_MAX-1];

    ////////////////////////////////////////////////////////////////////////////
    // Decoding
    logic enable, cplx, chOpt, modOn, take, idle, building, filtering, emitting;
    logic [1:0] rateShift;
    assign enable = ctrl_r[`IQE_B_EN];
    assign cplx = ctrl_r[`IQE_B_CPLX];
    assign chOpt = ctrl_r[`IQE_B_CHOPT];
    assign modOn = ctrl_r[`IQE_B_MOD];
    assign rateShift = ctrl_r[`IQE_B_RATE+:2];
    assign idle = state_r == IQE_IDLE;
    assign building = state_r == IQE_BUILD;
    assign filtering = state_r == IQE_FILT;
    assign emitting = state_r == IQE_EMIT;
    // Builds and mirrors run first so samples never see half-written taps
    assign inReady = idle && !buildReq_r && !mirrReq_r;
    assign take = inValid && inReady;

    // Tap budget and the central window of the combined response
    logic [9:0] usable, combLen, capLen, newLen, startOff;
    logic [6:0] chLenEff;
    assign usable = 10'(`IQE_TAP_MAX) - (ctrl_r[`IQE_B_SKEW] ? 10'(SKEW_TAP_CUT) : 10'h000)
        - (ctrl_r[`IQE_B_DELAY] ? 10'(DELAY_TAP_CUT) : 10'h000)
        - (chOpt ? 10'(CHOPT_TAP_CUT) : 10'h000);
    assign chLenEff = chOpt ? chLen_r : 7'h01;
    assign combLen = 10'(taps_r) + 10'(chLenEff) - 10'h001;
    assign capLen = (combLen > 10'(`IQE_TAP_MAX)) ? 10'(`IQE_TAP_MAX) : combLen;
    assign newLen = (capLen > usable) ? usable : capLen;
    assign startOff = (combLen - newLen) >> 1;

    // Channel optimization tap for the build; a unit impulse when it is off
    logic [11:0] chIdx;
    logic chIn;
    logic signed [DW-1:0] chCoef;
    assign chIdx = 12'(k_r) + 12'(startOff) - 12'(j_r);
    assign chIn = !chIdx[11] && (chIdx < 12'(chLenEff));
    assign chCoef = !chIn ? '0 : chOpt ? chCoefMem[chIdx[5:0]] : `IQE_UNITY;

    // Polyphase pick from the table at the optimal ratio
    logic [2:0] optLog2;
    logic [4:0] optOsr;
    logic [10:0] phaseOff, tblIdx;
    logic signed [DW-1:0] tblCoef;
    assign optLog2 = `IQE_RT_LOG2 - {1'b0, rateShift};
    assign optOsr = 5'h01 << optLog2;
    assign phaseOff = 11'((15'(k_r) * 15'(osr_r)) >> optLog2);
    assign tblIdx = base_r + phaseOff;
    assign tblCoef = (tblIdx < count_r) ? tbl[tblIdx[9:0]] : '0;

    // Loop ends
    logic [7:0] histIdx;
    logic lastStep, phaseLast, lastK, mirrLast, mirrDone, startBuild, startMirr;
    assign histIdx = wp_r - j_r[7:0];
    assign lastStep = building ? (j_r == 11'(taps_r) - 11'h001)
        : modeMod_r ? ((base_r + 11'(osr_r) >= count_r) || (j_r == `IQE_SYM_MAX - 11'h001))
        : (j_r + 11'h001 >= 11'(workLen_r));
    assign phaseLast = k_r == 9'(optOsr) - 9'h001;
    assign lastK = 10'(k_r) + 10'h001 >= newLen;
    assign mirrLast = (j_r + 11'h001 >= count_r) || (count_r + j_r == `IQE_TBL_MAX - 11'h001);
    assign mirrDone = state_r == IQE_MIRR && mirrLast;
    assign startBuild = idle && buildReq_r;
    assign startMirr = idle && !buildReq_r && mirrReq_r;

    ////////////////////////////////////////////////////////////////////////////
    // Arithmetic
    logic signed [DW-1:0] aRe, aIm, bRe, bIm;
    logic signed [AW-1:0] accRe, accIm;
    logic macRealMode;
    assign aRe = build_r ? eqRe[j_r[7:0]] : histI[histIdx];
    assign aIm = build_r ? eqIm[j_r[7:0]] : histQ[histIdx];
    assign bRe = building ? chCoef : modeMod_r ? tblCoef : workRe[j_r[7:0]];
    assign bIm = (building || modeMod_r) ? '0 : workIm[j_r[7:0]];
    assign macRealMode = !building && (modeMod_r || !cplx);

    iqe_cmac #(.DW(DW), .AW(AW)) mac (
        .clock(clock),
        .rst_n(rst_n),
        .clr(idle || emitting),
        .en(building || filtering),
        .realMode(macRealMode),
        .aRe(aRe),
        .aIm(aIm),
        .bRe(bRe),
        .bIm(bIm),
        .accRe(accRe),
        .accIm(accIm)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Register port
    logic [31:0] rdMux;
    logic tapsOk, osrOk, countOk, chLenOk;
    assign tapsOk = regWdata[8:0] >= `IQE_TAP_MIN && regWdata[8:0] <= `IQE_TAP_MAX
        && regWdata[31:9] == '0;
    assign osrOk = regWdata[5:0] >= `IQE_OSR_MIN && regWdata[5:0] <= `IQE_OSR_MAX
        && regWdata[31:6] == '0;
    assign countOk = regWdata[10:0] <= `IQE_TBL_MAX && regWdata[31:11] == '0;
    assign chLenOk = regWdata[6:0] != 7'h00 && regWdata[6:0] <= `IQE_CH_MAX
        && regWdata[31:7] == '0;
    assign rdMux = (regAddr == `IQE_A_CTRL) ? {24'h000000, ctrl_r}
        : (regAddr == `IQE_A_TAPS) ? {23'h000000, taps_r}
        : (regAddr == `IQE_A_OSR) ? {26'h0000000, osr_r}
        : (regAddr == `IQE_A_COUNT) ? {21'h000000, count_r}
        : (regAddr == `IQE_A_ADDR) ? {22'h000000, addr_r}
        : (regAddr == `IQE_A_CHLEN) ? {25'h0000000, chLen_r}
        : (regAddr == `IQE_A_STATUS) ? {11'h000, buildReq_r, !idle, workLen_r, usable}
        : 32'h00000000;
    assign regRdata = regRdata_r;

    // Clears come before the write so a request in the same cycle wins
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ctrl_r <= 8'h00;
            taps_r <= `IQE_TAP_MIN;
            osr_r <= `IQE_OSR_RST;
            count_r <= 11'h000;
            addr_r <= 10'h000;
            chLen_r <= 7'h01;
            buildReq_r <= 1'b0;
            mirrReq_r <= 1'b0;
            regRdata_r <= 32'h00000000;
        end else begin
            regRdata_r <= regRd ? rdMux : 32'h00000000;
            if (startBuild) begin
                buildReq_r <= 1'b0;
            end
            if (startMirr) begin
                mirrReq_r <= 1'b0;
            end
            if (mirrDone) begin
                count_r <= count_r + j_r + 11'h001;
            end
            if (regWr) begin
                case (regAddr)
                    `IQE_A_CTRL: begin
                        ctrl_r <= regWdata[7:0];
                        buildReq_r <= buildReq_r | regWdata[`IQE_B_BUILD];
                        mirrReq_r <= mirrReq_r | regWdata[`IQE_B_MIRROR];
                    end
                    `IQE_A_TAPS: taps_r <= tapsOk ? regWdata[8:0] : taps_r;
                    `IQE_A_OSR: osr_r <= osrOk ? regWdata[5:0] : osr_r;
                    `IQE_A_COUNT: count_r <= countOk ? regWdata[10:0] : count_r;
                    `IQE_A_ADDR: addr_r <= regWdata[9:0];
                    `IQE_A_CHLEN: chLen_r <= chLenOk ? regWdata[6:0] : chLen_r;
                    `IQE_A_EQDATA, `IQE_A_TBLDATA, `IQE_A_CHDATA: addr_r <= addr_r + 10'h001;
                    default: ;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Stores: no reset, software loads them before enabling
    always_ff @(posedge clock) begin
        if (regWr && regAddr == `IQE_A_EQDATA) begin
            eqRe[addr_r[7:0]] <= regWdata[15:0];
            eqIm[addr_r[7:0]] <= regWdata[31:16];
        end
        if (regWr && regAddr == `IQE_A_CHDATA) begin
            chCoefMem[addr_r[5:0]] <= regWdata[15:0];
        end
        if (state_r == IQE_MIRR) begin
            tbl[10'(count_r + j_r)] <= tbl[10'(count_r - j_r - 11'h001)];
        end else if (regWr && regAddr == `IQE_A_TBLDATA) begin
            tbl[addr_r] <= regWdata[15:0];
        end
        if (emitting && build_r) begin
            workRe[k_r[7:0]] <= satq(accRe);
            workIm[k_r[7:0]] <= satq(accIm);
        end
        if (take) begin
            histI[wp_r + 8'h01] <= inI;
            histQ[wp_r + 8'h01] <= inQ;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_r <= IQE_IDLE;
            j_r <= 11'h000;
            k_r <= 9'h000;
            base_r <= 11'h000;
            wp_r <= 8'h00;
            workLen_r <= 9'h001;
            build_r <= 1'b0;
            modeMod_r <= 1'b0;
            bypass_r <= 1'b1;
            capI_r <= '0;
            capQ_r <= '0;
            outValid_r <= 1'b0;
            outI_r <= '0;
            outQ_r <= '0;
        end else begin
            outValid_r <= 1'b0;
            case (state_r)
                IQE_IDLE: begin
                    j_r <= 11'h000;
                    k_r <= 9'h000;
                    base_r <= 11'h000;
                    if (startBuild) begin
                        build_r <= 1'b1;
                        modeMod_r <= 1'b0;
                        state_r <= IQE_BUILD;
                    end else if (startMirr) begin
                        state_r <= (count_r == 11'h000) ? IQE_IDLE : IQE_MIRR;
                    end else if (take) begin
                        wp_r <= wp_r + 8'h01;
                        capI_r <= inI;
                        capQ_r <= inQ;
                        modeMod_r <= modOn && srcInternal;
                        bypass_r <= !(modOn && srcInternal) && !(enable && srcInternal);
                        state_r <= IQE_FILT;
                    end
                end
                IQE_BUILD, IQE_FILT: begin
                    j_r <= j_r + 11'h001;
                    base_r <= base_r + 11'(osr_r);
                    state_r <= lastStep ? IQE_EMIT : state_r;
                end
                IQE_EMIT: begin
                    j_r <= 11'h000;
                    base_r <= 11'h000;
                    k_r <= k_r + 9'h001;
                    if (build_r) begin
                        state_r <= lastK ? IQE_IDLE : IQE_BUILD;
                        build_r <= !lastK;
                        workLen_r <= lastK ? 9'(newLen) : workLen_r;
                    end else begin
                        outValid_r <= 1'b1;
                        outI_r <= bypass_r ? capI_r : satq(accRe);
                        outQ_r <= bypass_r ? capQ_r : satq(accIm);
                        state_r <= (modeMod_r && !phaseLast) ? IQE_FILT : IQE_IDLE;
                    end
                end
                IQE_MIRR: begin
                    j_r <= j_r + 11'h001;
                    state_r <= mirrLast ? IQE_IDLE : IQE_MIRR;
                end
                default: state_r <= IQE_IDLE;
            endcase
        end
    end
    assign outValid = outValid_r;
    assign outI = outI_r;
    assign outQ = outQ_r;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    tapsRange_a: assert property (taps_r >= `IQE_TAP_MIN && taps_r <= `IQE_TAP_MAX)
        else $error("tap count outside 2..256");
    tableRange_a: assert property (osr_r >= `IQE_OSR_MIN && osr_r <= `IQE_OSR_MAX
        && count_r <= `IQE_TBL_MAX) else $error("table ratio or size out of range");
    oneOut_a: assert property (take && !(modOn && srcInternal) |=>
        !outValid [*1] ##[0:258] (outValid && idle)) else $error("sample gave no output");
    bypassSame_a: assert property (take && !srcInternal |=>
        bypass_r ##[1:259] (outValid && outI == $past(capI_r, 1))
        ) else $error("external sample was altered");
    disabledPass_a: assert property (outValid && bypass_r |->
        outI == capI_r && outQ == capQ_r) else $error("disabled path changed the sample");
    windowLen_a: assert property (idle |-> workLen_r <= `IQE_TAP_MAX
        && (build_r || 10'(workLen_r) <= usable || $changed(ctrl_r) || workLen_r == 9'h001))
        else $error("taps in use exceed the budget");
    rtRatio_a: assert property (modeMod_r && emitting |-> optOsr <= 5'h10
        && k_r < 9'(optOsr)) else $error("modulation ratio above 16");
    mirrorLen_a: assert property (mirrDone |=> count_r == $past(count_r) + $past(j_r) + 11'h001
        && count_r <= `IQE_TBL_MAX) else $error("mirror produced a wrong length");
    buildGate_a: assert property (buildReq_r && idle |=> building [*2]
        or (building ##1 emitting)) else $error("build request not started");
endmodule // iq_equalization_fir

// ### test/iqe_src_model.sv
// Baseband sample source model: offers one I/Q pair per handshake.
// Assumes inReady is combinational and stable between rising edges.
`timescale 1ns/10ps
`include "iqe_defs.svh"
module iqe_src_model (
    // Clock and handshake
    input wire logic clock,
    input wire logic inReady,
    output logic inValid,
    // Sample pair
    output logic srcInternal,
    output logic signed [`IQE_DW-1:0] inI,
    output logic signed [`IQE_DW-1:0] inQ
);
    initial begin
        inValid = 1'b0;
        srcInternal = 1'b1;
        inI = '0;
        inQ = '0;
    end
    // I and Q always travel together and stay put until taken
    task automatic send(input logic signed [15:0] i, input logic signed [15:0] q,
            input logic intl);
        @(posedge clock);
        inI <= i;
        inQ <= q;
        srcInternal <= intl;
        inValid <= 1'b1;
        do @(negedge clock); while (inReady !== 1'b1);
        @(posedge clock);
        inValid <= 1'b0;
        // Released lines show the inverse so stale data cannot pass for a match
        inI <= ~i;
        inQ <= ~q;
    endtask
endmodule // iqe_src_model

// ### test/iq_equalization_fir_tb.sv
// Self-checking bench: register port tasks and sample transfers with expected values.
// Assumes the design, its defines header and the source model are compiled before it.
`timescale 1ns/10ps
`include "iqe_defs.svh"
module iq_equalization_fir_tb;
    logic clock, rst_n, regWr, regRd, inValid, srcInternal, inReady, outValid;
    logic [3:0] regAddr;
    logic [31:0] regWdata, regRdata;
    logic signed [15:0] inI, inQ, outI, outQ;
    int err_count = 0;
    int checks_done = 0;
    iq_equalization_fir dut (.clock(clock), .rst_n(rst_n), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .inValid(inValid), .srcInternal(srcInternal), .inI(inI), .inQ(inQ),
        .inReady(inReady), .outValid(outValid), .outI(outI), .outQ(outQ));
    iqe_src_model src (.clock(clock), .inReady(inReady), .inValid(inValid),
        .srcInternal(srcInternal), .inI(inI), .inQ(inQ));
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clock);
        regWr <= 1'b0;
    endtask
    task automatic rdChk(input logic [3:0] a, input logic [31:0] exp, input logic [31:0] m);
        @(posedge clock);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clock);
        regRd <= 1'b0;
        @(negedge clock);
        chk(regRdata & m, exp);
    endtask
    // Build and mirror hold the stream off; poll busy and pending with a bound
    task automatic waitIdle();
        int n;
        n = 0;
        do begin
            @(posedge clock);
            regAddr <= `IQE_A_STATUS;
            regRd <= 1'b1;
            @(posedge clock);
            regRd <= 1'b0;
            @(negedge clock);
            n++;
        end while (regRdata[20:19] !== 2'h0 && n < 200);
        // A stuck build or mirror counts as a mismatch
        chk({30'h00000000, regRdata[20:19]}, 32'h0);
    endtask
    // Count cycles until the next answer; outputs are compared without sign extension
    task automatic waitOut(input logic [15:0] eI, input logic [15:0] eQ, input int lat);
        int n;
        n = 0;
        do begin
            @(negedge clock);
            n++;
        end while (outValid !== 1'b1 && n < 50);
        chk(n, lat);
        chk({16'h0000, outI}, {16'h0000, eI});
        chk({16'h0000, outQ}, {16'h0000, eQ});
    endtask
    // Send one pair, then wait for its answer
    task automatic xfer(input logic [15:0] i, input logic [15:0] q, input logic intl,
            input logic [15:0] eI, input logic [15:0] eQ, input int lat);
        src.send(i, q, intl);
        waitOut(eI, eQ, lat);
    endtask
    task automatic end_of_test();
        $display("checks=%0d mismatches=%0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        #(25 * 20000);
        err_count++;
        end_of_test();
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n = 1'b0;
        regWr = 1'b0;
        regRd = 1'b0;
        regAddr = 4'h0;
        regWdata = 32'h0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        rdChk(`IQE_A_TAPS, 32'h2, 32'h1FF);
        rdChk(`IQE_A_OSR, 32'h4, 32'h3F);
        rdChk(4'hF, 32'h0, 32'hFFFFFFFF);
        $display("test reset values done");
        wr(`IQE_A_TAPS, 32'h1);
        rdChk(`IQE_A_TAPS, 32'h2, 32'h1FF);
        wr(`IQE_A_TAPS, 32'h101);
        rdChk(`IQE_A_TAPS, 32'h2, 32'h1FF);
        wr(`IQE_A_TAPS, 32'h100);
        rdChk(`IQE_A_TAPS, 32'h100, 32'h1FF);
        wr(`IQE_A_OSR, 32'h21);
        rdChk(`IQE_A_OSR, 32'h4, 32'h3F);
        wr(`IQE_A_OSR, 32'h0);
        rdChk(`IQE_A_OSR, 32'h4, 32'h3F);
        wr(`IQE_A_OSR, 32'h20);
        rdChk(`IQE_A_OSR, 32'h20, 32'h3F);
        wr(`IQE_A_COUNT, 32'h401);
        rdChk(`IQE_A_COUNT, 32'h0, 32'h7FF);
        wr(`IQE_A_CTRL, 32'h8);
        rdChk(`IQE_A_STATUS, 32'hF8, 32'h3FF);
        wr(`IQE_A_CTRL, 32'h0);
        rdChk(`IQE_A_STATUS, 32'h100, 32'h3FF);
        $display("test limits done");
        xfer(16'h1234, 16'h8001, 1'b1, 16'h1234, 16'h8001, 3);
        $display("test bypass done");
        // Equalizer sets carry one coefficient per sample
        wr(`IQE_A_OSR, 32'h1);
        wr(`IQE_A_TAPS, 32'h2);
        wr(`IQE_A_ADDR, 32'h0);
        wr(`IQE_A_EQDATA, 32'h40004000);
        wr(`IQE_A_EQDATA, 32'h0);
        rdChk(`IQE_A_ADDR, 32'h2, 32'h3FF);
        wr(`IQE_A_CTRL, 32'h101);
        waitIdle();
        rdChk(`IQE_A_STATUS, 32'h800, 32'h7FC00);
        xfer(16'h1234, 16'h0567, 1'b1, 16'h1234, 16'h0567, 4);
        wr(`IQE_A_CTRL, 32'h3);
        xfer(16'h1234, 16'h0567, 1'b1, 16'h0CCD, 16'h179B, 4);
        xfer(16'h1234, 16'h0567, 1'b0, 16'h1234, 16'h0567, 4);
        wr(`IQE_A_CTRL, 32'h0);
        xfer(16'h7FFF, 16'hFFFF, 1'b1, 16'h7FFF, 16'hFFFF, 4);
        $display("test filter modes done");
        wr(`IQE_A_COUNT, 32'h10);
        wr(`IQE_A_ADDR, 32'h0);
        for (int k = 0; k < 16; k++)
            wr(`IQE_A_TBLDATA, 32'h100 * k);
        wr(`IQE_A_CTRL, 32'h200);
        waitIdle();
        rdChk(`IQE_A_COUNT, 32'h20, 32'h7FF);
        $display("test mirror done");
        // One real unity tap, optimal ratio 2: each symbol yields two equal outputs
        wr(`IQE_A_COUNT, 32'h1);
        wr(`IQE_A_ADDR, 32'h0);
        wr(`IQE_A_TBLDATA, 32'h4000);
        wr(`IQE_A_CTRL, 32'hE0);
        xfer(16'h1234, 16'h0567, 1'b1, 16'h1234, 16'h0567, 3);
        waitOut(16'h1234, 16'h0567, 2);
        $display("test modulation done");
        end_of_test();
    end
endmodule // iq_equalization_fir_tb
